/* File: design/pspc_pkg.sv */
// Package: parameter indices, subindices, codes and reset values for the switch point channels
package pspc_pkg;
    // Parameter indices and subindices
    localparam logic [7:0] IDX_CH1_SETPOINT   = 8'h40;
    localparam logic [7:0] IDX_CH1_CONFIG     = 8'h41;
    localparam logic [7:0] IDX_CH2_SETPOINT   = 8'h42;
    localparam logic [7:0] IDX_CH2_CONFIG     = 8'h43;
    localparam logic [7:0] IDX_COUNT_DIR      = 8'h61;
    localparam logic [7:0] IDX_AUX_SELECT     = 8'h65;
    localparam logic [7:0] SUB_ONE            = 8'h01;
    localparam logic [7:0] SUB_TWO            = 8'h02;
    localparam logic [7:0] SUB_THREE          = 8'h03;
    // Polarity codes
    localparam logic [7:0] POL_HIGH_ACTIVE    = 8'h00;
    localparam logic [7:0] POL_LOW_ACTIVE     = 8'h01;
    // Evaluation mode codes
    localparam logic [7:0] MODE_DEACTIVATED   = 8'h00;
    localparam logic [7:0] MODE_SINGLE_POINT  = 8'h01;
    localparam logic [7:0] MODE_WINDOW        = 8'h02;
    localparam logic [7:0] MODE_TWO_POINT     = 8'h03;
    // Auxiliary and direction codes
    localparam logic [7:0] AUX_DEACTIVATED    = 8'h00;
    localparam logic [7:0] AUX_TEMPERATURE    = 8'h01;
    localparam logic [7:0] DIR_CLOCKWISE      = 8'h00;
    localparam logic [7:0] DIR_COUNTER_CW     = 8'h01;
    // Reset values
    localparam logic [31:0] RST_SETPOINT      = 32'h0000_0000;
    localparam logic [15:0] RST_HYSTERESIS    = 16'h0000;
    localparam logic [7:0]  RST_POLARITY      = 8'h00;
    localparam logic [7:0]  RST_MODE          = 8'h00;
    localparam logic [7:0]  RST_COUNT_DIR     = 8'h00;
    localparam logic [7:0]  RST_AUX_SELECT    = 8'h00;
    // Sector numbering
    typedef enum logic [1:0] {
        SEC_OUTSIDE,
        SEC_LOW_BAND,
        SEC_INSIDE,
        SEC_HIGH_BAND
    } pspc_sector_type;
endpackage : pspc_pkg

/* File: design/pspc_channel.sv */
// Switch point comparator for one channel with mode, polarity and hysteresis
`timescale 1ns/100ps
module pspc_channel #(
    parameter int POS_W  = 32,
    parameter int HYST_W = 16
) (
    // Clock and reset
    input  wire logic                     clk_sys_i,
    input  wire logic                     arst_n_i,
    input  wire logic                     clk_en_i,
    // Position and parameters
    input  wire logic signed [POS_W-1:0]  measured_position_i,
    input  wire logic signed [POS_W-1:0]  first_setpoint_i,
    input  wire logic signed [POS_W-1:0]  second_setpoint_i,
    input  wire logic signed [HYST_W-1:0] hysteresis_i,
    input  wire logic        [7:0]        polarity_i,
    input  wire logic        [7:0]        mode_i,
    // Switching bit and registered sector
    output logic                          switch_o,
    output pspc_pkg::pspc_sector_type     sector_o
);
    // Two extra bits keep band edges from wrapping near the range limits
    localparam int EXT_W = POS_W + 2;

    logic signed [EXT_W-1:0] pos_x;
    logic signed [EXT_W-1:0] lo_x;
    logic signed [EXT_W-1:0] hi_x;
    logic signed [EXT_W-1:0] hyst_x;
    logic signed [EXT_W-1:0] lo_band;
    logic signed [EXT_W-1:0] hi_band;
    logic                    level_d;
    logic                    level_q;
    pspc_pkg::pspc_sector_type sector_d;
    pspc_pkg::pspc_sector_type sector_q;

    always_comb
    begin
        pos_x  = EXT_W'(measured_position_i);
        // Either setpoint may be the larger one [RQ3]
        if (first_setpoint_i <= second_setpoint_i)
        begin
            lo_x = EXT_W'(first_setpoint_i);
            hi_x = EXT_W'(second_setpoint_i);
        end
        else
        begin
            lo_x = EXT_W'(second_setpoint_i);
            hi_x = EXT_W'(first_setpoint_i);
        end
        // Negative hysteresis treated as none; hysteresis only in single and window [RQ8]
        if (hysteresis_i > 0 && (mode_i == pspc_pkg::MODE_SINGLE_POINT || mode_i == pspc_pkg::MODE_WINDOW))
            hyst_x = EXT_W'(hysteresis_i); // [RQ7]
        else
            hyst_x = '0;
        // Bands face away from the window [RQ9]
        lo_band = lo_x - hyst_x;
        hi_band = hi_x + hyst_x;
        // Sector classification [RQ10]
        if (pos_x >= lo_x && pos_x <= hi_x)
            sector_d = pspc_pkg::SEC_INSIDE;
        else if (pos_x < lo_x && pos_x >= lo_band)
            sector_d = pspc_pkg::SEC_LOW_BAND;
        else if (pos_x > hi_x && pos_x <= hi_band)
            sector_d = pspc_pkg::SEC_HIGH_BAND;
        else
            sector_d = pspc_pkg::SEC_OUTSIDE;
        level_d = level_q;
        case (mode_i)
            pspc_pkg::MODE_SINGLE_POINT,
            pspc_pkg::MODE_WINDOW:
            begin
                // Sector transitions, bands hold the prior level [RQ11] [RQ12]
                case (sector_d)
                    pspc_pkg::SEC_INSIDE:  level_d = 1'b0;
                    pspc_pkg::SEC_OUTSIDE: level_d = 1'b1;
                    default:               level_d = level_q;
                endcase
            end
            pspc_pkg::MODE_TWO_POINT:
            begin
                // Set above larger, clear below smaller [RQ18]
                if (pos_x > hi_x)
                    level_d = 1'b1;
                else if (pos_x < lo_x)
                    level_d = 1'b0;
            end
            default:
                level_d = 1'b0; // [RQ17]
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            level_q  <= 1'b0;
            sector_q <= pspc_pkg::SEC_OUTSIDE;
        end
        else if (clk_en_i)
        begin
            level_q  <= level_d;
            sector_q <= sector_d;
        end
    end

    // Active level per polarity; deactivated is inactive either way [RQ4] [RQ5] [RQ17]
    assign switch_o = (mode_i == pspc_pkg::MODE_DEACTIVATED) ? (polarity_i == pspc_pkg::POL_LOW_ACTIVE)
                    : (level_q ^ (polarity_i == pspc_pkg::POL_LOW_ACTIVE));
    assign sector_o = sector_q;
endmodule : pspc_channel

/* File: design/pspc_top.sv */
// Two switch point channels with their parameter store, direction and auxiliary select
//
// Summary of operation
// RQ1 - First setpoint of channel one is a signed 32-bit read/write value.
// RQ2 - Second setpoint of channel one is a signed 32-bit read/write value.
// RQ3 - Setpoints may be in any order; comparison never assumes which is larger.
// RQ4 - Eight-bit polarity picks active-high or active-low reporting of the bit.
// RQ5 - Default polarity drives high outside the switch points.
// RQ6 - Eight-bit mode picks deactivated, single point, window or two point.
// RQ7 - Signed 16-bit hysteresis separates switch-on and switch-off thresholds.
// RQ8 - Hysteresis acts only in single point and window modes.
// RQ9 - Window hysteresis bands lie outside the window.
// RQ10 - Positions fall into four sectors: outside, low band, inside, high band.
// RQ11 - Inside forces low, outside forces high, bands keep previous level.
// RQ12 - Single point mode uses the same sector behaviour.
// RQ13 - Eight-bit auxiliary setting chooses whether temperature enters process data.
// RQ14 - Eight-bit rotation setting chooses which shaft direction counts up.
// RQ15 - Auxiliary code 0 reports zero, code 1 reports ambient temperature.
// RQ16 - Second channel behaves identically with its own parameters.
// RQ17 - Deactivated mode holds the output at its inactive level.
// RQ18 - Two point sets above the larger setpoint, clears below the smaller.
`timescale 1ns/100ps
module pspc_top #(
    parameter int POS_W  = 32,
    parameter int HYST_W = 16,
    parameter int AUX_W  = 16
) (
    // Clock, reset, enable
    input  wire logic                     clk_sys_i,
    input  wire logic                     arst_n_i,
    input  wire logic                     clk_en_i,
    // Parameter access by index and subindex
    input  wire logic                     prm_wr_i,
    input  wire logic                     prm_rd_i,
    input  wire logic        [7:0]        prm_index_i,
    input  wire logic        [7:0]        prm_subindex_i,
    input  wire logic        [31:0]       prm_wdata_i,
    output logic             [31:0]       prm_rdata_o,
    output logic                          prm_rvalid_o,
    output logic                          prm_error_o,
    // Measured values from the sensing front end
    input  wire logic signed [POS_W-1:0]  measured_position_i,
    input  wire logic signed [AUX_W-1:0]  ambient_temperature_i,
    // Process data
    output logic                          switch_channel_one_o,
    output logic                          switch_channel_two_o,
    output logic signed      [AUX_W-1:0]  auxiliary_measured_value_o,
    output logic             [7:0]        auxiliary_status_o,
    output logic                          count_direction_ccw_o
);
    localparam int NCH = 2;

    logic signed [POS_W-1:0]  sp1_d [NCH];
    logic signed [POS_W-1:0]  sp1_q [NCH];
    logic signed [POS_W-1:0]  sp2_d [NCH];
    logic signed [POS_W-1:0]  sp2_q [NCH];
    logic signed [HYST_W-1:0] hyst_d [NCH];
    logic signed [HYST_W-1:0] hyst_q [NCH];
    logic        [7:0]        pol_d [NCH];
    logic        [7:0]        pol_q [NCH];
    logic        [7:0]        mode_d [NCH];
    logic        [7:0]        mode_q [NCH];
    logic        [7:0]        dir_d;
    logic        [7:0]        dir_q;
    logic        [7:0]        aux_sel_d;
    logic        [7:0]        aux_sel_q;
    logic        [31:0]       rdata_d;
    logic        [31:0]       rdata_q;
    logic                     rvalid_d;
    logic                     rvalid_q;
    logic                     error_d;
    logic                     error_q;
    logic signed [AUX_W-1:0]  aux_d;
    logic signed [AUX_W-1:0]  aux_q;
    logic                     sw_bit [NCH];

    // Channel number of an index, or NCH when it is no channel index
    function automatic int chan_of(input logic [7:0] idx, input logic [7:0] base);
        int r;
        r = NCH;
        for (int c = 0; c < NCH; c++)
        begin
            if (idx == base + 8'(2 * c))
                r = c;
        end
        return r;
    endfunction : chan_of

    // Unsupported codes are refused so the stored mode stays decodable
    function automatic logic mode_ok(input logic [7:0] m);
        return m <= pspc_pkg::MODE_TWO_POINT;
    endfunction : mode_ok

    always_comb
    begin
        int cs;
        int cc;
        cs = chan_of(prm_index_i, pspc_pkg::IDX_CH1_SETPOINT);
        cc = chan_of(prm_index_i, pspc_pkg::IDX_CH1_CONFIG);
        for (int c = 0; c < NCH; c++)
        begin
            sp1_d[c]  = sp1_q[c];
            sp2_d[c]  = sp2_q[c];
            hyst_d[c] = hyst_q[c];
            pol_d[c]  = pol_q[c];
            mode_d[c] = mode_q[c];
        end
        dir_d     = dir_q;
        aux_sel_d = aux_sel_q;
        rdata_d   = rdata_q;
        rvalid_d  = 1'b0;
        error_d   = 1'b0;
        if (prm_wr_i)
        begin
            if (cs < NCH && prm_subindex_i == pspc_pkg::SUB_ONE)
                sp1_d[cs] = POS_W'(prm_wdata_i); // [RQ1] [RQ16]
            else if (cs < NCH && prm_subindex_i == pspc_pkg::SUB_TWO)
                sp2_d[cs] = POS_W'(prm_wdata_i); // [RQ2] [RQ16]
            else if (cc < NCH && prm_subindex_i == pspc_pkg::SUB_ONE)
                pol_d[cc] = prm_wdata_i[7:0]; // [RQ4]
            else if (cc < NCH && prm_subindex_i == pspc_pkg::SUB_TWO && mode_ok(prm_wdata_i[7:0]))
                mode_d[cc] = prm_wdata_i[7:0]; // [RQ6]
            else if (cc < NCH && prm_subindex_i == pspc_pkg::SUB_THREE)
                hyst_d[cc] = HYST_W'(prm_wdata_i); // [RQ7]
            else if (prm_index_i == pspc_pkg::IDX_COUNT_DIR)
                dir_d = prm_wdata_i[7:0]; // [RQ14]
            else if (prm_index_i == pspc_pkg::IDX_AUX_SELECT)
                aux_sel_d = prm_wdata_i[7:0]; // [RQ13]
            else
                error_d = 1'b1;
        end
        else if (prm_rd_i)
        begin
            rvalid_d = 1'b1;
            if (cs < NCH && prm_subindex_i == pspc_pkg::SUB_ONE)
                rdata_d = 32'(sp1_q[cs]);
            else if (cs < NCH && prm_subindex_i == pspc_pkg::SUB_TWO)
                rdata_d = 32'(sp2_q[cs]);
            else if (cc < NCH && prm_subindex_i == pspc_pkg::SUB_ONE)
                rdata_d = {24'h000000, pol_q[cc]};
            else if (cc < NCH && prm_subindex_i == pspc_pkg::SUB_TWO)
                rdata_d = {24'h000000, mode_q[cc]};
            else if (cc < NCH && prm_subindex_i == pspc_pkg::SUB_THREE)
                rdata_d = 32'(hyst_q[cc]);
            else if (prm_index_i == pspc_pkg::IDX_COUNT_DIR)
                rdata_d = {24'h000000, dir_q};
            else if (prm_index_i == pspc_pkg::IDX_AUX_SELECT)
                rdata_d = {24'h000000, aux_sel_q};
            else
            begin
                rdata_d = 32'h0000_0000;
                error_d = 1'b1;
            end
        end
        // Zero unless temperature is selected [RQ15]
        if (aux_sel_q == pspc_pkg::AUX_TEMPERATURE)
            aux_d = ambient_temperature_i;
        else
            aux_d = '0;
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            for (int c = 0; c < NCH; c++)
            begin
                sp1_q[c]  <= POS_W'(pspc_pkg::RST_SETPOINT);
                sp2_q[c]  <= POS_W'(pspc_pkg::RST_SETPOINT);
                hyst_q[c] <= HYST_W'(pspc_pkg::RST_HYSTERESIS);
                pol_q[c]  <= pspc_pkg::RST_POLARITY;
                mode_q[c] <= pspc_pkg::RST_MODE;
            end
            dir_q     <= pspc_pkg::RST_COUNT_DIR;
            aux_sel_q <= pspc_pkg::RST_AUX_SELECT;
            rdata_q   <= 32'h0000_0000;
            rvalid_q  <= 1'b0;
            error_q   <= 1'b0;
            aux_q     <= '0;
        end
        else if (clk_en_i)
        begin
            for (int c = 0; c < NCH; c++)
            begin
                sp1_q[c]  <= sp1_d[c];
                sp2_q[c]  <= sp2_d[c];
                hyst_q[c] <= hyst_d[c];
                pol_q[c]  <= pol_d[c];
                mode_q[c] <= mode_d[c];
            end
            dir_q     <= dir_d;
            aux_sel_q <= aux_sel_d;
            rdata_q   <= rdata_d;
            rvalid_q  <= rvalid_d;
            error_q   <= error_d;
            aux_q     <= aux_d;
        end
    end

    // Identical independent channels [RQ16]
    for (genvar g = 0; g < NCH; g++)
    begin : gen_chan
        pspc_channel #(
            .POS_W  (POS_W),
            .HYST_W (HYST_W)
        ) u_chan (
            .clk_sys_i           (clk_sys_i),
            .arst_n_i            (arst_n_i),
            .clk_en_i            (clk_en_i),
            .measured_position_i (measured_position_i),
            .first_setpoint_i    (sp1_q[g]),
            .second_setpoint_i   (sp2_q[g]),
            .hysteresis_i        (hyst_q[g]),
            .polarity_i          (pol_q[g]),
            .mode_i              (mode_q[g]),
            .switch_o            (sw_bit[g]),
            .sector_o            ()
        );
    end

    assign switch_channel_one_o       = sw_bit[0];
    assign switch_channel_two_o       = sw_bit[1];
    assign prm_rdata_o                = rdata_q;
    assign prm_rvalid_o               = rvalid_q;
    assign prm_error_o                = error_q;
    assign auxiliary_measured_value_o = aux_q;
    assign auxiliary_status_o         = aux_sel_q;
    // Position counter outside uses this to pick its counting sense [RQ14]
    assign count_direction_ccw_o      = (dir_q == pspc_pkg::DIR_COUNTER_CW);
endmodule : pspc_top

/* File: verif/pspc_sva.sv */
// Checker for parameter answers and process data of the switch point block
`timescale 1ns/100ps
module pspc_sva #(
    parameter int AUX_W = 16
) (
    // Clock and reset
    input wire logic                    clk_sys_i,
    input wire logic                    arst_n_i,
    input wire logic                    clk_en_i,
    // Parameter access
    input wire logic                    prm_wr_i,
    input wire logic                    prm_rd_i,
    input wire logic [7:0]              prm_index_i,
    input wire logic [31:0]             prm_rdata_o,
    input wire logic                    prm_rvalid_o,
    input wire logic                    prm_error_o,
    // Process data
    input wire logic signed [AUX_W-1:0] ambient_temperature_i,
    input wire logic                    switch_channel_one_o,
    input wire logic                    switch_channel_two_o,
    input wire logic signed [AUX_W-1:0] auxiliary_measured_value_o,
    input wire logic [7:0]              auxiliary_status_o,
    input wire logic                    count_direction_ccw_o
);
    default clocking dcb @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);
    sequence read_taken;
        prm_rd_i && !prm_wr_i && clk_en_i;
    endsequence
    sequence read_answered;
        prm_rvalid_o || prm_error_o;
    endsequence
    read_answer_a: assert property (read_taken |=> read_answered)
        else $error("read not answered");
    rvalid_cause_a: assert property (prm_rvalid_o && $past(clk_en_i) |-> $past(prm_rd_i) && !$past(prm_wr_i))
        else $error("answer without read");
    error_cause_a: assert property (prm_error_o && $past(clk_en_i) |-> $past(prm_wr_i) || $past(prm_rd_i))
        else $error("error without access");
    refused_zero_a: assert property (prm_error_o && $past(prm_rd_i) && !$past(prm_wr_i) && $past(clk_en_i)
        |-> prm_rdata_o == 32'h0)
        else $error("refused read data not zero");
    rdata_hold_a: assert property (!prm_rvalid_o && !prm_error_o |-> $stable(prm_rdata_o))
        else $error("read data moved");
    freeze_hold_a: assert property (!$past(clk_en_i) |-> $stable(switch_channel_one_o)
        && $stable(switch_channel_two_o) && $stable(auxiliary_measured_value_o))
        else $error("outputs moved while frozen");
    aux_follow_a: assert property ($past(clk_en_i) && $past(auxiliary_status_o) == pspc_pkg::AUX_TEMPERATURE
        |-> auxiliary_measured_value_o == $past(ambient_temperature_i))
        else $error("temperature not passed");
    aux_zero_a: assert property ($past(clk_en_i) && $past(auxiliary_status_o) != pspc_pkg::AUX_TEMPERATURE
        |-> auxiliary_measured_value_o == '0)
        else $error("auxiliary value not zero");
    status_write_a: assert property ($changed(auxiliary_status_o) |-> $past(prm_wr_i) && $past(clk_en_i)
        && $past(prm_index_i) == pspc_pkg::IDX_AUX_SELECT)
        else $error("aux select moved without write");
    dir_write_a: assert property ($changed(count_direction_ccw_o) |-> $past(prm_wr_i) && $past(clk_en_i)
        && $past(prm_index_i) == pspc_pkg::IDX_COUNT_DIR)
        else $error("direction moved without write");
endmodule : pspc_sva
bind pspc_top pspc_sva #(.AUX_W(AUX_W)) u_sva (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i),
    .prm_wr_i(prm_wr_i), .prm_rd_i(prm_rd_i), .prm_index_i(prm_index_i), .prm_rdata_o(prm_rdata_o),
    .prm_rvalid_o(prm_rvalid_o), .prm_error_o(prm_error_o), .ambient_temperature_i(ambient_temperature_i),
    .switch_channel_one_o(switch_channel_one_o), .switch_channel_two_o(switch_channel_two_o),
    .auxiliary_measured_value_o(auxiliary_measured_value_o), .auxiliary_status_o(auxiliary_status_o),
    .count_direction_ccw_o(count_direction_ccw_o));

/* File: verif/pspc_master.sv */
// Master model: one parameter write or read per call
`timescale 1ns/100ps
module pspc_master (
    // Clock
    input  wire logic        clk_sys_i,
    // Requests
    output logic             prm_wr_o,
    output logic             prm_rd_o,
    output logic [7:0]       prm_index_o,
    output logic [7:0]       prm_subindex_o,
    output logic [31:0]      prm_wdata_o,
    // Answers
    input  wire logic [31:0] prm_rdata_i,
    input  wire logic        prm_rvalid_i,
    input  wire logic        prm_error_i
);
    initial
    begin
        prm_wr_o = 1'b0;
        prm_rd_o = 1'b0;
        prm_index_o = 8'hFF;
        prm_subindex_o = 8'hFF;
        prm_wdata_o = 32'h0;
    end
    // Setpoints go out in whatever order the caller asks
    task automatic access(input logic wr, input logic [7:0] idx, input logic [7:0] sub, input logic [31:0] wd,
                          output logic [31:0] rd, output logic vld, output logic err);
        @(posedge clk_sys_i);
        prm_wr_o <= wr;
        prm_rd_o <= ~wr;
        prm_index_o <= idx;
        prm_subindex_o <= sub;
        prm_wdata_o <= wd;
        @(posedge clk_sys_i);
        prm_wr_o <= 1'b0;
        prm_rd_o <= 1'b0;
        // Idle lines show the inverse so stale values cannot pass
        prm_index_o <= ~idx;
        prm_subindex_o <= ~sub;
        prm_wdata_o <= ~wd;
        @(posedge clk_sys_i);
        rd = prm_rdata_i;
        vld = prm_rvalid_i;
        err = prm_error_i;
    endtask : access
endmodule : pspc_master

/* File: verif/pspc_top_tb.sv */
// Self-checking bench for the switch point block
`timescale 1ns/100ps
module pspc_top_tb;
    logic               clk_sys_i = 1'b0;
    logic               arst_n_i = 1'b0;
    logic               clk_en_i = 1'b1;
    logic               prm_wr_i;
    logic               prm_rd_i;
    logic [7:0]         prm_index_i;
    logic [7:0]         prm_subindex_i;
    logic [31:0]        prm_wdata_i;
    logic [31:0]        prm_rdata_o;
    logic               prm_rvalid_o;
    logic               prm_error_o;
    logic signed [31:0] measured_position_i = 32'h0;
    logic signed [15:0] ambient_temperature_i = 16'h0;
    logic               switch_channel_one_o;
    logic               switch_channel_two_o;
    logic signed [15:0] auxiliary_measured_value_o;
    logic [7:0]         auxiliary_status_o;
    logic               count_direction_ccw_o;
    logic [31:0]        r32;
    logic               vld;
    logic               err;
    int                 failures = 0;
    int                 n_tests = 0;
    // Window 100..200, bands 90..99 and 201..210
    logic signed [31:0] pos_t [9] = '{32'h0, 32'h5F, 32'h96, 32'hCD, 32'hD3, 32'hCD, 32'h64, 32'h5F, 32'h59};
    logic               lvl_t [9] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    always #50 clk_sys_i = ~clk_sys_i;
    pspc_top u_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i), .prm_wr_i(prm_wr_i),
        .prm_rd_i(prm_rd_i), .prm_index_i(prm_index_i), .prm_subindex_i(prm_subindex_i), .prm_wdata_i(prm_wdata_i),
        .prm_rdata_o(prm_rdata_o), .prm_rvalid_o(prm_rvalid_o), .prm_error_o(prm_error_o),
        .measured_position_i(measured_position_i), .ambient_temperature_i(ambient_temperature_i),
        .switch_channel_one_o(switch_channel_one_o), .switch_channel_two_o(switch_channel_two_o),
        .auxiliary_measured_value_o(auxiliary_measured_value_o), .auxiliary_status_o(auxiliary_status_o),
        .count_direction_ccw_o(count_direction_ccw_o));
    pspc_master u_mst (.clk_sys_i(clk_sys_i), .prm_wr_o(prm_wr_i), .prm_rd_o(prm_rd_i), .prm_index_o(prm_index_i),
        .prm_subindex_o(prm_subindex_i), .prm_wdata_o(prm_wdata_i), .prm_rdata_i(prm_rdata_o),
        .prm_rvalid_i(prm_rvalid_o), .prm_error_i(prm_error_o));
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t bit %b expected %b", $time, got, exp);
        end
    endtask : chk_bit
    task automatic wr(input logic [7:0] idx, input logic [7:0] sub, input logic [31:0] d, input logic e);
        u_mst.access(1'b1, idx, sub, d, r32, vld, err);
        chk_bit(err, e);
    endtask : wr
    task automatic rd(input logic [7:0] idx, input logic [7:0] sub, input logic [31:0] exp, input logic e);
        u_mst.access(1'b0, idx, sub, 32'h0, r32, vld, err);
        chk_bit(err, e);
        if (!e)
            chk_bit(vld, 1'b1);
        chk_word(r32, exp);
    endtask : rd
    task automatic walk(input logic ch2, input logic signed [31:0] p, input logic e);
        @(posedge clk_sys_i);
        measured_position_i <= p;
        repeat (2) @(posedge clk_sys_i);
        chk_bit(ch2 ? switch_channel_two_o : switch_channel_one_o, e);
    endtask : walk
    task automatic t_regs;
        chk_bit(switch_channel_one_o | switch_channel_two_o, 1'b0);
        for (int c = 0; c < 4; c++)
            for (int s = 1; s <= 3; s++)
                if (c[0] || s < 3)
                    rd(8'h40 + 8'(c), 8'(s), 32'h0, 1'b0);
        wr(8'h40, 8'h01, 32'h8000_0001, 1'b0);
        wr(8'h40, 8'h02, 32'h7FFF_FFFF, 1'b0);
        rd(8'h40, 8'h01, 32'h8000_0001, 1'b0);
        rd(8'h40, 8'h02, 32'h7FFF_FFFF, 1'b0);
        wr(8'h41, 8'h03, 32'h0000_FFF6, 1'b0);
        rd(8'h41, 8'h03, 32'hFFFF_FFF6, 1'b0);
        wr(8'h41, 8'h01, 32'hFFFF_FF01, 1'b0);
        rd(8'h41, 8'h01, 32'h1, 1'b0);
        wr(8'h41, 8'h02, 32'h2, 1'b0);
        wr(8'h41, 8'h02, 32'h4, 1'b1);
        rd(8'h41, 8'h02, 32'h2, 1'b0);
        rd(8'h44, 8'h01, 32'h0, 1'b1);
        rd(8'h43, 8'h04, 32'h0, 1'b1);
        rd(8'h61, 8'h00, 32'h0, 1'b0);
        rd(8'h65, 8'h00, 32'h0, 1'b0);
    endtask : t_regs
    task automatic run_sectors(input logic [7:0] base, input logic [7:0] mode, input logic [7:0] pol);
        wr(base, 8'h01, 32'hC8, 1'b0);
        wr(base, 8'h02, 32'h64, 1'b0);
        wr(base + 8'h01, 8'h03, 32'hA, 1'b0);
        wr(base + 8'h01, 8'h01, {24'h0, pol}, 1'b0);
        wr(base + 8'h01, 8'h02, 32'h0, 1'b0);
        wr(base + 8'h01, 8'h02, {24'h0, mode}, 1'b0);
        for (int i = 0; i < 9; i++)
            walk(base[1], pos_t[i], lvl_t[i] ^ pol[0]);
    endtask : run_sectors
    task automatic t_two;
        wr(8'h41, 8'h01, 32'h1, 1'b0);
        wr(8'h41, 8'h02, 32'h0, 1'b0);
        walk(1'b0, 32'h96, 1'b1);
        wr(8'h41, 8'h01, 32'h0, 1'b0);
        walk(1'b0, 32'h0, 1'b0);
        wr(8'h41, 8'h02, 32'h3, 1'b0);
        walk(1'b0, 32'h96, 1'b0);
        walk(1'b0, 32'hC9, 1'b1);
        walk(1'b0, 32'h96, 1'b1);
        walk(1'b0, 32'h63, 1'b0);
        walk(1'b0, 32'hC9, 1'b1);
    endtask : t_two
    task automatic t_freeze;
        @(posedge clk_sys_i);
        clk_en_i <= 1'b0;
        measured_position_i <= 32'h32;
        repeat (4) @(posedge clk_sys_i);
        chk_bit(switch_channel_one_o, 1'b1);
        clk_en_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        chk_bit(switch_channel_one_o, 1'b0);
    endtask : t_freeze
    task automatic t_aux;
        ambient_temperature_i <= 16'h8123;
        wr(8'h65, 8'h00, 32'h1, 1'b0);
        @(posedge clk_sys_i);
        chk_word({16'h0, auxiliary_measured_value_o}, 32'h8123);
        chk_word({24'h0, auxiliary_status_o}, 32'h1);
        wr(8'h65, 8'h00, 32'h2, 1'b0);
        @(posedge clk_sys_i);
        chk_word({16'h0, auxiliary_measured_value_o}, 32'h0);
        rd(8'h65, 8'h00, 32'h2, 1'b0);
        wr(8'h61, 8'h00, 32'h1, 1'b0);
        chk_bit(count_direction_ccw_o, 1'b1);
        rd(8'h61, 8'h00, 32'h1, 1'b0);
        wr(8'h61, 8'h00, 32'h0, 1'b0);
        chk_bit(count_direction_ccw_o, 1'b0);
    endtask : t_aux
    task automatic stop_test;
        if (failures == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    initial
    begin
        repeat (20) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        t_regs();
        run_sectors(8'h40, 8'h02, 8'h00);
        run_sectors(8'h40, 8'h01, 8'h00);
        chk_bit(switch_channel_two_o, 1'b0);
        run_sectors(8'h42, 8'h02, 8'h01);
        t_two();
        t_freeze();
        t_aux();
        stop_test();
    end
    initial
    begin
        #3_000_000;
        failures++;
        stop_test();
    end
endmodule : pspc_top_tb
